// >>> core/alpa_pkg.sv
// shared constants and types of the lite protection adapter
`default_nettype none
package alpa_pkg;
   // ----------------------------------------------------------------
   // response and burst encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [1:0] BURST_WRAP = 2'h2;
   localparam logic [3:0] CACHE_PLAIN = 4'h0;
   localparam logic [7:0] LEN_SINGLE = 8'h00;
   localparam logic [31:0] RDATA_ERR = 32'h0000_0000;

   // ----------------------------------------------------------------
   // build levels
   // ----------------------------------------------------------------
   localparam int LEVEL_FULL_CONV = 0;
   localparam int LEVEL_SIMPLE_PROT = 1;
   localparam int LEVEL_FULL_PROT = 2;

   // ----------------------------------------------------------------
   // state machines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      W_IDLE = 3'b000,
      W_DATA = 3'b001,
      W_SEND = 3'b010,
      W_BWAIT = 3'b011,
      W_DRAIN = 3'b100,
      W_RESP = 3'b101
   } alpa_wstate_e;

   typedef enum logic [2:0] {
      R_IDLE = 3'b000,
      R_SEND = 3'b001,
      R_WAIT = 3'b010,
      R_OUT = 3'b011,
      R_ERR = 3'b100
   } alpa_rstate_e;
endpackage
`default_nettype wire

// >>> core/alpa_addr_step.sv
// next-beat address generator for fixed, incrementing and wrapping bursts
`default_nettype none
module alpa_addr_step #(
   parameter int ADDR_W = 32
) (
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [2:0] size,
   input wire logic [7:0] len,
   input wire logic [1:0] burst,
   output logic [ADDR_W-1:0] next_addr
);
   logic [ADDR_W-1:0] incr;
   logic [ADDR_W-1:0] aligned;
   logic [ADDR_W-1:0] sum;
   logic [ADDR_W-1:0] wrap_mask;

   always_comb begin
      incr = ADDR_W'(1) << size;
      // unaligned start: later beats fall on size-aligned boundaries
      aligned = addr & ~(incr - ADDR_W'(1));
      sum = aligned + incr;
      wrap_mask = ((ADDR_W'(len) + ADDR_W'(1)) << size) - ADDR_W'(1);
      case (burst)
         alpa_pkg::BURST_FIXED: next_addr = addr;
         alpa_pkg::BURST_WRAP: next_addr = (addr & ~wrap_mask) |
            (sum & wrap_mask);
         default: next_addr = sum;
      endcase
   end
endmodule
`default_nettype wire

// >>> core/alpa_adapter.sv
// full-protocol slave port to lite master port protection adapter
`default_nettype none
module alpa_adapter #(
   parameter int LEVEL = alpa_pkg::LEVEL_SIMPLE_PROT,
   parameter bit DETECT = 1'b1,
   parameter int ID_W = 4,
   parameter int ADDR_W = 32,
   parameter int DATA_W = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ID_W-1:0] s_awid,
   input wire logic [ADDR_W-1:0] s_awaddr,
   input wire logic [7:0] s_awlen,
   input wire logic [2:0] s_awsize,
   input wire logic [1:0] s_awburst,
   input wire logic s_awlock,
   input wire logic [3:0] s_awcache,
   input wire logic [2:0] s_awprot,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [DATA_W-1:0] s_wdata,
   input wire logic [DATA_W/8-1:0] s_wstrb,
   input wire logic s_wlast,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [ID_W-1:0] s_bid,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [ID_W-1:0] s_arid,
   input wire logic [ADDR_W-1:0] s_araddr,
   input wire logic [7:0] s_arlen,
   input wire logic [2:0] s_arsize,
   input wire logic [1:0] s_arburst,
   input wire logic s_arlock,
   input wire logic [3:0] s_arcache,
   input wire logic [2:0] s_arprot,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [ID_W-1:0] s_rid,
   output logic [DATA_W-1:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rlast,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [ADDR_W-1:0] m_awaddr,
   output logic [2:0] m_awprot,
   output logic m_awvalid,
   input wire logic m_awready,
   output logic [DATA_W-1:0] m_wdata,
   output logic [DATA_W/8-1:0] m_wstrb,
   output logic m_wvalid,
   input wire logic m_wready,
   input wire logic [1:0] m_bresp,
   input wire logic m_bvalid,
   output logic m_bready,
   output logic [ADDR_W-1:0] m_araddr,
   output logic [2:0] m_arprot,
   output logic m_arvalid,
   input wire logic m_arready,
   input wire logic [DATA_W-1:0] m_rdata,
   input wire logic [1:0] m_rresp,
   input wire logic m_rvalid,
   output logic m_rready,
   output logic violation_pulse
);
   localparam logic [2:0] FULL_SIZE = 3'($clog2(DATA_W / 8));

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (DATA_W != 32 && DATA_W != 64) begin : g_bad_width
      $error("lite data width must be 32 or 64");
   end
   if (LEVEL < alpa_pkg::LEVEL_FULL_CONV ||
       LEVEL > alpa_pkg::LEVEL_FULL_PROT) begin : g_bad_level
      $error("unknown adapter level");
   end

   // ----------------------------------------------------------------
   // classification: bit 1 reject, bit 0 report
   // ----------------------------------------------------------------
   function automatic logic [1:0] classify(input logic [7:0] len,
      input logic [2:0] size, input logic lock, input logic [3:0] cache);
      logic simple;
      logic complex;
      logic rej;
      simple = lock || (cache != alpa_pkg::CACHE_PLAIN);
      // narrower than the port passes directly; only wider is a fault
      complex = (len != alpa_pkg::LEN_SINGLE) || (size > FULL_SIZE);
      case (LEVEL)
         alpa_pkg::LEVEL_FULL_CONV: rej = 1'b0;
         alpa_pkg::LEVEL_SIMPLE_PROT: rej = complex;
         default: rej = simple || complex;
      endcase
      classify = {rej, rej || (DETECT && (simple || complex))};
   endfunction

   // first error received wins, later ones cannot overwrite it
   function automatic logic [1:0] merge(input logic [1:0] acc,
      input logic [1:0] resp);
      merge = (acc == alpa_pkg::RESP_OKAY) ? resp : acc;
   endfunction

   logic [1:0] aw_class;
   logic [1:0] ar_class;
   logic aw_hs;
   logic ar_hs;
   assign aw_class = classify(s_awlen, s_awsize, s_awlock, s_awcache);
   assign ar_class = classify(s_arlen, s_arsize, s_arlock, s_arcache);
   assign aw_hs = s_awvalid && s_awready;
   assign ar_hs = s_arvalid && s_arready;

   // ----------------------------------------------------------------
   // write path
   // ----------------------------------------------------------------
   alpa_pkg::alpa_wstate_e wst;
   logic [7:0] w_len;
   logic [7:0] w_cnt;
   logic [2:0] w_size;
   logic [1:0] w_burst;
   logic aw_pend;
   logic w_pend;
   logic [ADDR_W-1:0] w_next;

   alpa_addr_step #(.ADDR_W(ADDR_W)) u_wstep (
      .addr(m_awaddr),
      .size(w_size),
      .len(w_len),
      .burst(w_burst),
      .next_addr(w_next)
   );

   assign s_awready = (wst == alpa_pkg::W_IDLE);
   assign s_wready = (wst == alpa_pkg::W_DATA) ||
      (wst == alpa_pkg::W_DRAIN);
   assign s_bvalid = (wst == alpa_pkg::W_RESP);
   assign m_awvalid = aw_pend;
   assign m_wvalid = w_pend;
   assign m_bready = (wst == alpa_pkg::W_BWAIT);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wst <= alpa_pkg::W_IDLE;
         w_cnt <= 8'h00;
         aw_pend <= 1'b0;
         w_pend <= 1'b0;
         s_bresp <= alpa_pkg::RESP_OKAY;
      end else begin
         case (wst)
            alpa_pkg::W_IDLE: if (aw_hs) begin
               w_cnt <= 8'h00;
               s_bresp <= alpa_pkg::RESP_OKAY;
               wst <= aw_class[1] ? alpa_pkg::W_DRAIN : alpa_pkg::W_DATA;
            end
            // beats counted against the length; master last unused
            alpa_pkg::W_DATA: if (s_wvalid) begin
               aw_pend <= 1'b1;
               w_pend <= 1'b1;
               wst <= alpa_pkg::W_SEND;
            end
            alpa_pkg::W_SEND: begin
               if (m_awready) aw_pend <= 1'b0;
               if (m_wready) w_pend <= 1'b0;
               if ((!aw_pend || m_awready) && (!w_pend || m_wready)) begin
                  wst <= alpa_pkg::W_BWAIT;
               end
            end
            alpa_pkg::W_BWAIT: if (m_bvalid) begin
               s_bresp <= merge(s_bresp, m_bresp);
               w_cnt <= w_cnt + 8'h01;
               wst <= (w_cnt == w_len) ? alpa_pkg::W_RESP :
                  alpa_pkg::W_DATA;
            end
            // swallow every data beat so the master is not stuck
            alpa_pkg::W_DRAIN: if (s_wvalid) begin
               w_cnt <= w_cnt + 8'h01;
               if (w_cnt == w_len) begin
                  s_bresp <= alpa_pkg::RESP_SLVERR;
                  wst <= alpa_pkg::W_RESP;
               end
            end
            alpa_pkg::W_RESP: if (s_bready) wst <= alpa_pkg::W_IDLE;
            default: wst <= alpa_pkg::W_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_bid <= '0;
         w_len <= 8'h00;
         w_size <= 3'h0;
         w_burst <= alpa_pkg::BURST_INCR;
         m_awaddr <= '0;
         m_awprot <= 3'h0;
         m_wdata <= '0;
         m_wstrb <= '0;
      end else begin
         if (aw_hs) begin
            s_bid <= s_awid;
            w_len <= s_awlen;
            w_size <= s_awsize;
            w_burst <= s_awburst;
            m_awaddr <= s_awaddr;
            // lock and cache end here; prot passes unchanged
            m_awprot <= s_awprot;
         end
         if (wst == alpa_pkg::W_DATA && s_wvalid) begin
            m_wdata <= s_wdata;
            m_wstrb <= s_wstrb;
         end
         if (wst == alpa_pkg::W_BWAIT && m_bvalid) begin
            m_awaddr <= w_next;
         end
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   alpa_pkg::alpa_rstate_e rst;
   logic [7:0] r_len;
   logic [7:0] r_cnt;
   logic [2:0] r_size;
   logic [1:0] r_burst;
   logic [ADDR_W-1:0] r_next;

   alpa_addr_step #(.ADDR_W(ADDR_W)) u_rstep (
      .addr(m_araddr),
      .size(r_size),
      .len(r_len),
      .burst(r_burst),
      .next_addr(r_next)
   );

   assign s_arready = (rst == alpa_pkg::R_IDLE);
   assign s_rvalid = (rst == alpa_pkg::R_OUT) || (rst == alpa_pkg::R_ERR);
   assign m_arvalid = (rst == alpa_pkg::R_SEND);
   assign m_rready = (rst == alpa_pkg::R_WAIT);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rst <= alpa_pkg::R_IDLE;
         r_cnt <= 8'h00;
         s_rdata <= '0;
         s_rresp <= alpa_pkg::RESP_OKAY;
         s_rlast <= 1'b0;
      end else begin
         case (rst)
            alpa_pkg::R_IDLE: if (ar_hs) begin
               r_cnt <= 8'h00;
               if (ar_class[1]) begin
                  s_rdata <= DATA_W'(alpa_pkg::RDATA_ERR);
                  s_rresp <= alpa_pkg::RESP_SLVERR;
                  s_rlast <= (s_arlen == alpa_pkg::LEN_SINGLE);
                  rst <= alpa_pkg::R_ERR;
               end else begin
                  rst <= alpa_pkg::R_SEND;
               end
            end
            alpa_pkg::R_SEND: if (m_arready) rst <= alpa_pkg::R_WAIT;
            // each lite read beat closes its own single transfer
            alpa_pkg::R_WAIT: if (m_rvalid) begin
               s_rdata <= m_rdata;
               s_rresp <= m_rresp;
               s_rlast <= (r_cnt == r_len);
               rst <= alpa_pkg::R_OUT;
            end
            alpa_pkg::R_OUT: if (s_rready) begin
               r_cnt <= r_cnt + 8'h01;
               rst <= s_rlast ? alpa_pkg::R_IDLE : alpa_pkg::R_SEND;
            end
            alpa_pkg::R_ERR: if (s_rready) begin
               r_cnt <= r_cnt + 8'h01;
               s_rlast <= ((r_cnt + 8'h01) == r_len);
               if (s_rlast) rst <= alpa_pkg::R_IDLE;
            end
            default: rst <= alpa_pkg::R_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_rid <= '0;
         r_len <= 8'h00;
         r_size <= 3'h0;
         r_burst <= alpa_pkg::BURST_INCR;
         m_araddr <= '0;
         m_arprot <= 3'h0;
      end else begin
         if (ar_hs) begin
            s_rid <= s_arid;
            r_len <= s_arlen;
            r_size <= s_arsize;
            r_burst <= s_arburst;
            m_araddr <= s_araddr;
            m_arprot <= s_arprot;
         end
         if (rst == alpa_pkg::R_OUT && s_rready) begin
            m_araddr <= r_next;
         end
      end
   end

   // ----------------------------------------------------------------
   // notification
   // ----------------------------------------------------------------
   // a write and a read flagged together share one pulse
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         violation_pulse <= 1'b0;
      end else begin
         violation_pulse <= (aw_hs && aw_class[0]) ||
            (ar_hs && ar_class[0]);
      end
   end
endmodule
`default_nettype wire

// >>> verif/alpa_properties.sv
// concurrent port checks of the lite protection adapter, bound into every adapter instance
`default_nettype none
module alpa_checker #(
   parameter int LEVEL = 1,
   parameter bit DETECT = 1'b1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] s_awlen,
   input wire logic [2:0] s_awsize,
   input wire logic s_awlock,
   input wire logic [3:0] s_awcache,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic [1:0] s_bresp,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_arlen,
   input wire logic [2:0] s_arsize,
   input wire logic s_arlock,
   input wire logic [3:0] s_arcache,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [1:0] s_rresp,
   input wire logic s_rlast,
   input wire logic s_rvalid,
   input wire logic m_awvalid,
   input wire logic m_wvalid,
   input wire logic [1:0] m_bresp,
   input wire logic m_bvalid,
   input wire logic m_bready,
   input wire logic m_arvalid,
   input wire logic m_rvalid,
   input wire logic m_rready,
   input wire logic violation_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // violation classes, 32-bit data path assumed
   // ----
   logic ar_cx, aw_cx, ar_bad, aw_bad, ar_rej, aw_rej, flag;
   assign ar_cx = s_arlen != 8'h00 || s_arsize > 3'h2;
   assign aw_cx = s_awlen != 8'h00 || s_awsize > 3'h2;
   assign ar_bad = ar_cx || s_arlock || s_arcache != 4'h0;
   assign aw_bad = aw_cx || s_awlock || s_awcache != 4'h0;
   assign ar_rej = LEVEL == 2 ? ar_bad : LEVEL == 1 && ar_cx;
   assign aw_rej = LEVEL == 2 ? aw_bad : LEVEL == 1 && aw_cx;
   assign flag = (s_arvalid && s_arready && (ar_rej || DETECT && ar_bad))
      || (s_awvalid && s_awready && (aw_rej || DETECT && aw_bad));
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_ar_rej;
      s_arvalid && s_arready && ar_rej;
   endsequence
   sequence s_ar_fwd;
      s_arvalid && s_arready && !ar_rej;
   endsequence
   sequence s_aw_rej;
      s_awvalid && s_awready && aw_rej;
   endsequence
   AST_AR_REJ: assert property (
      s_ar_rej |=> s_rvalid && !m_arvalid)
      else $error("rejected read reached the lite side");
   AST_RD_ERR: assert property (
      s_ar_rej ##0 s_arlen != 8'h00 |=> s_rresp == 2'h2 && !s_rlast)
      else $error("rejected burst first beat wrong");
   AST_RD_LAST: assert property (
      LEVEL != 0 && m_rvalid && m_rready |=> s_rvalid && s_rlast)
      else $error("lite read not passed on as final beat");
   AST_AR_FWD: assert property (
      s_ar_fwd |=> m_arvalid)
      else $error("accepted read not forwarded");
   AST_WR_REJ: assert property (
      s_aw_rej |=> (!m_awvalid && !m_wvalid) [*2])
      else $error("rejected write reached the lite side");
   AST_B_HOLD: assert property (
      s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write answer dropped before taken");
   AST_B_PASS: assert property (
      LEVEL != 0 && m_bvalid && m_bready
         |=> s_bvalid && s_bresp == $past(m_bresp))
      else $error("lite write answer not passed up");
   AST_FLAG_CAUSE: assert property (
      violation_pulse |-> $past(flag))
      else $error("notify pulse without a violation");
   AST_FLAG_EFFECT: assert property (
      flag |=> violation_pulse)
      else $error("violation not notified");
endmodule
bind alpa_adapter alpa_checker #(.LEVEL(LEVEL), .DETECT(DETECT))
   u_chk (.*);
`default_nettype wire

// >>> verif/alpa_lite_peer.sv
// lite slave model that echoes the read address and answers with resp
`default_nettype none
module alpa_lite_peer (
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic [1:0] resp,
   input wire logic m_awvalid,
   output logic m_awready,
   input wire logic m_wvalid,
   output logic m_wready,
   output logic [1:0] m_bresp,
   output logic m_bvalid,
   input wire logic m_bready,
   input wire logic [31:0] m_araddr,
   input wire logic m_arvalid,
   output logic m_arready,
   output logic [31:0] m_rdata,
   output logic [1:0] m_rresp,
   output logic m_rvalid,
   input wire logic m_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;
   logic got_aw, got_w, go;
   logic [31:0] addr;
   // slow mode accepts one cycle in four
   assign go = !slow || cnt == 2'h3;
   assign m_awready = go && !got_aw;
   assign m_wready = go && !got_w;
   assign m_arready = go && !m_rvalid;
   // idle answer lines never show the last value
   assign m_bresp = m_bvalid ? resp : ~resp;
   assign m_rresp = m_rvalid ? resp : ~resp;
   assign m_rdata = m_rvalid ? addr : ~addr;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= 2'h0;
         got_aw <= 1'b0;
         got_w <= 1'b0;
         m_bvalid <= 1'b0;
         m_rvalid <= 1'b0;
         addr <= 32'h0;
      end else begin
         cnt <= cnt + 2'h1;
         if (m_awvalid && m_awready) got_aw <= 1'b1;
         if (m_wvalid && m_wready) got_w <= 1'b1;
         if (got_aw && got_w && !m_bvalid) begin
            m_bvalid <= 1'b1;
            got_aw <= 1'b0;
            got_w <= 1'b0;
         end
         if (m_bvalid && m_bready) m_bvalid <= 1'b0;
         if (m_arvalid && m_arready) begin
            m_rvalid <= 1'b1;
            addr <= m_araddr;
         end
         if (m_rvalid && m_rready) m_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> verif/test_axi4_lite_protection_adapter.sv
// self-checking bench of the lite protection adapter with a lite peer
`default_nettype none
module test_axi4_lite_protection_adapter;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, slow, s_awlock, s_awvalid, s_awready, s_wlast;
   logic s_wvalid, s_wready, s_bvalid, s_bready, s_arlock, s_arvalid;
   logic s_arready, s_rlast, s_rvalid, s_rready, m_awvalid, m_awready;
   logic m_wvalid, m_wready, m_bvalid, m_bready, m_arvalid, m_arready;
   logic m_rvalid, m_rready, violation_pulse;
   logic [3:0] s_awid, s_bid, s_arid, s_rid, s_awcache, s_arcache;
   logic [3:0] s_wstrb, m_wstrb;
   logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, rnd;
   logic [31:0] rr = 32'h0000_a680;
   logic [31:0] m_awaddr, m_wdata, m_araddr, m_rdata;
   logic [7:0] s_awlen, s_arlen;
   logic [2:0] s_awsize, s_arsize, s_awprot, s_arprot, m_awprot, m_arprot;
   logic [1:0] s_awburst, s_arburst, s_bresp, s_rresp, m_bresp, m_rresp;
   logic [1:0] resp;
   logic f_awvalid, f_awready, f_wvalid, f_wready, f_bready, f_bvalid;
   logic f_arvalid, f_arready, f_rvalid, f_rready, f_pulse;
   logic [1:0] f_bresp, f_rresp;
   logic [31:0] f_araddr, f_rdata;
   logic [38:0] rq[$];
   logic [38:0] re;
   logic [5:0] bq[$];
   int failures, compares, fwd, pulses, exp_fwd, exp_pulses, cyc;
   int fwd_full, exp_full, pulses_full;
   // plain, lock, cache, burst, wide, burst with lock and cache
   logic [7:0] c_len [6] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h01};
   logic [2:0] c_size [6] = '{3'h2, 3'h1, 3'h2, 3'h2, 3'h3, 3'h0};
   logic [4:0] c_lc [6] = '{5'h00, 5'h10, 5'h03, 5'h00, 5'h00, 5'h12};

   alpa_adapter #(.LEVEL(alpa_pkg::LEVEL_SIMPLE_PROT)) dut (.*);
   alpa_lite_peer peer (.*);

   // protection-only copy driven by the same master stimulus
   alpa_adapter #(.LEVEL(alpa_pkg::LEVEL_FULL_PROT)) dut_full (
      .clk(clk), .reset(reset), .s_awid(s_awid), .s_awaddr(s_awaddr),
      .s_awlen(s_awlen), .s_awsize(s_awsize), .s_awburst(s_awburst),
      .s_awlock(s_awlock), .s_awcache(s_awcache), .s_awprot(s_awprot),
      .s_awvalid(s_awvalid), .s_awready(), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wlast(s_wlast), .s_wvalid(s_wvalid),
      .s_wready(), .s_bid(), .s_bresp(), .s_bvalid(), .s_bready(s_bready),
      .s_arid(s_arid), .s_araddr(s_araddr), .s_arlen(s_arlen),
      .s_arsize(s_arsize), .s_arburst(s_arburst), .s_arlock(s_arlock),
      .s_arcache(s_arcache), .s_arprot(s_arprot), .s_arvalid(s_arvalid),
      .s_arready(), .s_rid(), .s_rdata(), .s_rresp(), .s_rlast(),
      .s_rvalid(), .s_rready(s_rready), .m_awaddr(), .m_awprot(),
      .m_awvalid(f_awvalid), .m_awready(f_awready), .m_wdata(),
      .m_wstrb(), .m_wvalid(f_wvalid), .m_wready(f_wready),
      .m_bresp(f_bresp), .m_bvalid(f_bvalid), .m_bready(f_bready),
      .m_araddr(f_araddr), .m_arprot(), .m_arvalid(f_arvalid),
      .m_arready(f_arready), .m_rdata(f_rdata), .m_rresp(f_rresp),
      .m_rvalid(f_rvalid), .m_rready(f_rready), .violation_pulse(f_pulse)
   );

   alpa_lite_peer peer_full (
      .clk(clk), .reset(reset), .slow(slow), .resp(resp),
      .m_awvalid(f_awvalid), .m_awready(f_awready), .m_wvalid(f_wvalid),
      .m_wready(f_wready), .m_bresp(f_bresp), .m_bvalid(f_bvalid),
      .m_bready(f_bready), .m_araddr(f_araddr), .m_arvalid(f_arvalid),
      .m_arready(f_arready), .m_rdata(f_rdata), .m_rresp(f_rresp),
      .m_rvalid(f_rvalid), .m_rready(f_rready)
   );

   always #5 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic chk(input string what, input logic [39:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ----
   // one read then one write of case i
   // ----
   task automatic run(input int i);
      logic rej, bad;
      rej = c_len[i] != 8'h00 || c_size[i] > 3'h2;
      bad = rej || c_lc[i] != 5'h00;
      exp_fwd += rej ? 0 : 2;
      exp_pulses += bad ? 2 : 0;
      exp_full += bad ? 0 : 2;
      rnd = lfsr(rnd);
      @(negedge clk);
      s_araddr = {rnd[31:2], 2'b00};
      {s_arid, s_arprot} = rnd[6:0];
      {s_arlen, s_arsize, s_arlock, s_arcache} =
         {c_len[i], c_size[i], c_lc[i]};
      s_arburst = alpa_pkg::BURST_INCR;
      for (int b = 0; b <= c_len[i]; b++)
         rq.push_back(rej ? {s_arid, alpa_pkg::RESP_SLVERR, b == c_len[i],
            alpa_pkg::RDATA_ERR} : {s_arid, resp, 1'b1, s_araddr});
      s_arvalid = 1'b1;
      while (!s_arready) @(negedge clk);
      @(negedge clk);
      s_arvalid = 1'b0;
      while (rq.size() != 0) @(negedge clk);
      s_awaddr = {rnd[29:0], 2'b00};
      {s_awid, s_awprot} = rnd[13:7];
      {s_awlen, s_awsize, s_awlock, s_awcache} =
         {c_len[i], c_size[i], c_lc[i]};
      s_awburst = alpa_pkg::BURST_INCR;
      bq.push_back({s_awid, rej ? alpa_pkg::RESP_SLVERR : resp});
      s_awvalid = 1'b1;
      while (!s_awready) @(negedge clk);
      @(negedge clk);
      s_awvalid = 1'b0;
      for (int b = 0; b <= c_len[i]; b++) begin
         rnd = lfsr(rnd);
         {s_wdata, s_wstrb, s_wlast} = {rnd, rnd[7:4], rnd[9]};
         s_wvalid = 1'b1;
         while (!s_wready) @(negedge clk);
         @(negedge clk);
      end
      s_wvalid = 1'b0;
      while (bq.size() != 0) @(negedge clk);
      chk("forwarded", fwd, exp_fwd);
      chk("notices", pulses, exp_pulses);
      chk("protected", fwd_full, exp_full);
      chk("full notices", pulses_full, exp_pulses);
   endtask

   always @(negedge clk) begin
      rr = lfsr(rr);
      s_rready = rr[1:0] != 2'h0;
      s_bready = rr[3:2] != 2'h0;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         finish_test();
      end
      if (!reset) begin
         if (s_rvalid === 1'b1 && s_rready) begin
            re = rq.pop_front();
            chk("rd", {s_rid, s_rresp, s_rlast, s_rdata}, re);
         end
         if (s_bvalid === 1'b1 && s_bready)
            chk("wr", {s_bid, s_bresp}, bq.pop_front());
         if (m_awvalid === 1'b1 && m_awready) begin
            fwd++;
            chk("aw", {m_awaddr, m_awprot}, {s_awaddr, s_awprot});
         end
         if (m_wvalid === 1'b1 && m_wready)
            chk("w", {m_wdata, m_wstrb}, {s_wdata, s_wstrb});
         if (m_arvalid === 1'b1 && m_arready) begin
            fwd++;
            chk("ar", {m_araddr, m_arprot}, {s_araddr, s_arprot});
         end
         if (violation_pulse === 1'b1) pulses++;
         if (f_awvalid === 1'b1 && f_awready) fwd_full++;
         if (f_arvalid === 1'b1 && f_arready) fwd_full++;
         if (f_pulse === 1'b1) pulses_full++;
      end
   end

   initial begin
      {clk, reset, slow, resp, rnd} = {3'h2, 2'h0, 32'h0000_a680};
      {s_awvalid, s_wvalid, s_arvalid, s_wlast} = 4'h0;
      {s_awlock, s_arlock, s_awcache, s_arcache, s_awid, s_arid} = 18'h0;
      {s_wstrb, s_awlen, s_arlen, s_awburst, s_arburst} = 24'h0;
      {s_awsize, s_arsize, s_awprot, s_arprot} = 12'h000;
      {s_awaddr, s_araddr, s_wdata} = 96'h0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      for (int p = 0; p < 3; p++) begin
         slow = p[0];
         resp = p == 0 ? alpa_pkg::RESP_OKAY
            : p == 1 ? alpa_pkg::RESP_SLVERR : alpa_pkg::RESP_DECERR;
         for (int i = 0; i < 6; i++) begin
            run(i);
            $display("test %0d.%0d done", p, i);
         end
      end
      finish_test();
   end
endmodule
`default_nettype wire
